// file: common/cbv_pkg.sv
// Shared constants and types for the current balance and code decode block
package cbv_pkg;

  // Clock and setup timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SEL_SETUP_NS = 1000;
  localparam int SEL_SETUP_CYC_I =
    (SEL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] SEL_SETUP_CYC = 10'(SEL_SETUP_CYC_I);

  // Widths
  localparam int CHANNELS = 4;
  localparam int CUR_W = 12;
  localparam int WIDTH_W = 16;
  localparam int REF_W = 14;
  localparam int CODE_W = 6;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CHANNELS = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_BASE_WIDTH = 8'h08;
  localparam logic [7:0] OFS_SERIAL_REF = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_REF = 8'h14;
  localparam logic [7:0] OFS_AVERAGE = 8'h18;
  localparam logic [7:0] OFS_ERROR0 = 8'h20;

  // Status field positions
  localparam int ST_CORE_EN = 0;
  localparam int ST_SEC_EN = 1;
  localparam int ST_PARALLEL = 2;
  localparam int ST_SERIAL = 3;
  localparam int ST_SETUP_SHORT = 4;
  localparam int ST_CODE_LSB = 8;

  // Reset values and limits
  localparam logic [2:0] RST_CHANNELS = 3'h4;
  localparam logic [2:0] MIN_CHANNELS = 3'h2;
  localparam logic [15:0] RST_PERIOD = 16'h00FA;
  localparam logic [15:0] MIN_PERIOD = 16'h0004;
  localparam logic [15:0] RST_BASE_WIDTH = 16'h0064;
  localparam logic [13:0] RST_SERIAL_REF = 14'h0000;
  localparam int FILT_SHIFT = 2;

  // Reference levels in units of 0.1 mV
  localparam logic [13:0] REF_TOP = 14'h3C8C;
  localparam logic [13:0] REF_STEP_HI = 14'h00FA;
  localparam logic [13:0] REF_MID = 14'h1DC9;
  localparam logic [13:0] REF_STEP_LO = 14'h007D;
  localparam logic [13:0] REF_SAFE = 14'h101D;
  localparam logic [5:0] CODE_SPLIT = 6'h20;
  localparam logic [5:0] CODE_LAST = 6'h3C;

  // Divide by three as multiply and shift
  localparam logic [31:0] THIRD_MUL = 32'h0000_5556;

  // Operating mode, gray coded
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_SERIAL = 2'h1,
    MODE_PARALLEL = 2'h3
  } cbv_mode_type;

  // Balance sequence, gray coded
  typedef enum logic [1:0] {
    BAL_IDLE = 2'h0,
    BAL_AVG = 2'h1,
    BAL_UPD = 2'h3
  } cbv_bal_type;

  // Per channel result
  typedef struct packed {
    logic signed [15:0] balance_error;
    logic [15:0] pulse_width;
  } cbv_chan_out_type;

endpackage

// file: hdl/cbv_balance_chan.sv
// One channel of the current balance loop: error filter and width trim
`timescale 1ns/1ns
module cbv_balance_chan (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic active,
  input wire logic update,
  input wire logic [11:0] sample,
  input wire logic [11:0] average,
  input wire logic [15:0] base_width,
  // Result
  output cbv_pkg::cbv_chan_out_type result
);

  logic signed [15:0] err;
  logic signed [15:0] filt_d;
  logic signed [15:0] filt_q;
  logic signed [17:0] width_s;
  logic [15:0] width_d;
  logic [15:0] width_q;

  // Error, filter and trimmed width
  always_comb begin
    err = $signed({4'h0, sample}) - $signed({4'h0, average});
    filt_d = filt_q + ((err - filt_q) >>> cbv_pkg::FILT_SHIFT);
    width_s = $signed({2'b00, base_width}) - 18'(filt_d);
    if (width_s < 0) begin
      width_d = 16'h0000;
    end else if (width_s > 18'sh0FFFF) begin
      width_d = 16'hFFFF;
    end else begin
      width_d = width_s[15:0];
    end
  end

  // Filter state; inactive channel held at zero
  always_ff @(posedge clk) begin
    if (reset || !active) begin
      filt_q <= 16'sh0000;
      width_q <= 16'h0000;
    end else if (update) begin
      filt_q <= filt_d;
      width_q <= width_d;
    end
  end

  assign result.balance_error = filt_q;
  assign result.pulse_width = width_q;

endmodule // cbv_balance_chan

// file: hdl/cbv_top.sv
// Mode capture, parallel code decode and channel current balance
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module cbv_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins
  input wire logic enable_pin,
  input wire logic mode_select_code_bit1,
  input wire logic code_bit0,
  input wire logic code_bit2,
  input wire logic code_bit3,
  input wire logic code_bit4,
  input wire logic code_bit5,
  // Channel current samples from sensing logic
  input wire logic [3:0][11:0] channel_current,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Regulator control
  output logic core_regulator_enable,
  output logic secondary_regulator_enable,
  output logic parallel_code_mode,
  output logic serial_code_mode,
  output logic [13:0] reference_level,
  output logic [15:0] cycle_average_current,
  output cbv_pkg::cbv_chan_out_type [3:0] channel_out
);

  // Reference level for a parallel code
  function automatic logic [13:0] ref_of(input logic [5:0] code);
    logic [13:0] r;
    r = cbv_pkg::REF_SAFE;
    if (code < cbv_pkg::CODE_SPLIT) begin
      r = cbv_pkg::REF_TOP - 14'(code) * cbv_pkg::REF_STEP_HI;
    end else if (code <= cbv_pkg::CODE_LAST) begin
      r = cbv_pkg::REF_MID -
        14'(code - cbv_pkg::CODE_SPLIT) * cbv_pkg::REF_STEP_LO;
    end
    return r;
  endfunction

  // Average of a sum over the active channel count
  function automatic logic [11:0] avg_of(input logic [13:0] sum,
                                         input logic [2:0] count);
    logic [31:0] p;
    logic [11:0] a;
    p = 32'(sum) * cbv_pkg::THIRD_MUL;
    case (count)
      3'h2: a = sum[12:1];
      3'h3: a = p[27:16];
      default: a = sum[13:2];
    endcase
    return a;
  endfunction

  // Pin synchronisers
  logic [6:0] pin_meta_q;
  logic [6:0] pin_sync_q;
  logic en_s;
  logic sel_s;
  logic [5:0] code_s;

  // Mode capture
  logic en_prev_q;
  logic en_rise;
  logic sel_prev_q;
  logic [9:0] sel_stable_q;
  logic setup_short_q;
  cbv_pkg::cbv_mode_type mode_q;
  cbv_pkg::cbv_mode_type mode_d;
  logic core_en_q;
  logic sec_en_q;
  logic [13:0] ref_q;

  // Software registers
  logic [2:0] chan_count_q;
  logic [15:0] period_q;
  logic [15:0] base_width_q;
  logic [13:0] serial_ref_q;

  // Bus slave
  logic req;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_en;

  // Balance sequence
  logic [15:0] timer_q;
  logic cycle_start;
  cbv_pkg::cbv_bal_type bal_q;
  logic [3:0][11:0] samples_q;
  logic [3:0] active;
  logic [13:0] sum;
  logic [11:0] avg_q;
  logic update;

  // Two flops on every pin before use
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta_q <= 7'h00;
      pin_sync_q <= 7'h00;
    end else begin
      pin_meta_q <= {enable_pin, code_bit5, code_bit4, code_bit3,
                     code_bit2, mode_select_code_bit1, code_bit0};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign en_s = pin_sync_q[6];
  assign sel_s = pin_sync_q[1];
  assign code_s = pin_sync_q[5:0]; // Shared pin is code bit 1
  assign en_rise = en_s && !en_prev_q;

  // Enable edge and select stability tracking
  always_ff @(posedge clk) begin
    if (reset) begin
      en_prev_q <= 1'b0;
      sel_prev_q <= 1'b0;
      sel_stable_q <= 10'h000;
    end else begin
      en_prev_q <= en_s;
      sel_prev_q <= sel_s;
      if (sel_s != sel_prev_q) begin
        sel_stable_q <= 10'h000;
      end else if (sel_stable_q < cbv_pkg::SEL_SETUP_CYC) begin
        sel_stable_q <= sel_stable_q + 10'h001;
      end
    end
  end

  // Flags a select that moved too close to the enable edge
  always_ff @(posedge clk) begin
    if (reset) begin
      setup_short_q <= 1'b0;
    end else if (en_rise) begin
      setup_short_q <= (sel_s != sel_prev_q) ||
        (sel_stable_q < cbv_pkg::SEL_SETUP_CYC);
    end
  end

  // Mode selection
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      cbv_pkg::MODE_OFF: begin
        if (en_rise) begin
          if (sel_s) begin
            mode_d = cbv_pkg::MODE_PARALLEL;
          end else begin
            mode_d = cbv_pkg::MODE_SERIAL;
          end
        end
      end
      cbv_pkg::MODE_SERIAL, cbv_pkg::MODE_PARALLEL: begin
        if (!en_s) begin
          mode_d = cbv_pkg::MODE_OFF;
        end
      end
      default: mode_d = cbv_pkg::MODE_OFF;
    endcase
  end

  // Mode register and regulator enables
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= cbv_pkg::MODE_OFF;
      core_en_q <= 1'b0;
      sec_en_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      core_en_q <= (mode_d != cbv_pkg::MODE_OFF);
      sec_en_q <= (mode_d == cbv_pkg::MODE_SERIAL);
    end
  end

  // Reference level follows the mode
  always_ff @(posedge clk) begin
    if (reset) begin
      ref_q <= 14'h0000;
    end else begin
      case (mode_q)
        cbv_pkg::MODE_PARALLEL: ref_q <= ref_of(code_s);
        cbv_pkg::MODE_SERIAL: ref_q <= serial_ref_q;
        default: ref_q <= 14'h0000;
      endcase
    end
  end

  // Avalon slave: one wait state, then answer
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign wr_en = avs_write && ack_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Read data mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (avs_address)
      cbv_pkg::OFS_CHANNELS: rdata_d = 32'(chan_count_q);
      cbv_pkg::OFS_PERIOD: rdata_d = 32'(period_q);
      cbv_pkg::OFS_BASE_WIDTH: rdata_d = 32'(base_width_q);
      cbv_pkg::OFS_SERIAL_REF: rdata_d = 32'(serial_ref_q);
      cbv_pkg::OFS_STATUS: begin
        rdata_d[cbv_pkg::ST_CORE_EN] = core_en_q;
        rdata_d[cbv_pkg::ST_SEC_EN] = sec_en_q;
        rdata_d[cbv_pkg::ST_PARALLEL] =
          (mode_q == cbv_pkg::MODE_PARALLEL);
        rdata_d[cbv_pkg::ST_SERIAL] = (mode_q == cbv_pkg::MODE_SERIAL);
        rdata_d[cbv_pkg::ST_SETUP_SHORT] = setup_short_q;
        rdata_d[cbv_pkg::ST_CODE_LSB +: 6] = code_s;
      end
      cbv_pkg::OFS_REF: rdata_d = 32'(ref_q);
      cbv_pkg::OFS_AVERAGE: rdata_d = 32'(avg_q);
      default: begin
        for (int i = 0; i < cbv_pkg::CHANNELS; i++) begin
          if (avs_address == cbv_pkg::OFS_ERROR0 + 8'(4 * i)) begin
            rdata_d = 32'(channel_out[i].balance_error);
          end
        end
      end
    endcase
  end

  // Read data captured in the wait cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;

  // Software writes; out of range values ignored or clamped
  always_ff @(posedge clk) begin
    if (reset) begin
      chan_count_q <= cbv_pkg::RST_CHANNELS;
      period_q <= cbv_pkg::RST_PERIOD;
      base_width_q <= cbv_pkg::RST_BASE_WIDTH;
      serial_ref_q <= cbv_pkg::RST_SERIAL_REF;
    end else if (wr_en) begin
      case (avs_address)
        cbv_pkg::OFS_CHANNELS: begin
          if (avs_writedata[2:0] >= cbv_pkg::MIN_CHANNELS &&
              avs_writedata[31:3] == 29'h0 &&
              avs_writedata[2:0] <= cbv_pkg::RST_CHANNELS) begin
            chan_count_q <= avs_writedata[2:0];
          end
        end
        cbv_pkg::OFS_PERIOD: begin
          if (avs_writedata[15:0] < cbv_pkg::MIN_PERIOD) begin
            period_q <= cbv_pkg::MIN_PERIOD;
          end else begin
            period_q <= avs_writedata[15:0];
          end
        end
        cbv_pkg::OFS_BASE_WIDTH: base_width_q <= avs_writedata[15:0];
        cbv_pkg::OFS_SERIAL_REF: serial_ref_q <= avs_writedata[13:0];
        default: ;
      endcase
    end
  end

  // Switching cycle timer, runs only while the core is on
  assign cycle_start = core_en_q && (timer_q == 16'h0000);

  always_ff @(posedge clk) begin
    if (reset || !core_en_q) begin
      timer_q <= 16'h0000;
    end else if (cycle_start) begin
      timer_q <= period_q - 16'h0001;
    end else begin
      timer_q <= timer_q - 16'h0001;
    end
  end

  // Active channel mask from channel count
  always_comb begin
    for (int i = 0; i < cbv_pkg::CHANNELS; i++) begin
      active[i] = core_en_q && (3'(i) < chan_count_q);
    end
  end

  // Sum of active samples
  always_comb begin
    sum = 14'h0000;
    for (int i = 0; i < cbv_pkg::CHANNELS; i++) begin
      if (active[i]) begin
        sum = sum + 14'(samples_q[i]);
      end
    end
  end

  // Sample, average, update sequence per switching cycle
  always_ff @(posedge clk) begin
    if (reset || !core_en_q) begin
      bal_q <= cbv_pkg::BAL_IDLE;
    end else begin
      case (bal_q)
        cbv_pkg::BAL_IDLE: begin
          if (cycle_start) begin
            bal_q <= cbv_pkg::BAL_AVG;
          end
        end
        cbv_pkg::BAL_AVG: bal_q <= cbv_pkg::BAL_UPD;
        cbv_pkg::BAL_UPD: bal_q <= cbv_pkg::BAL_IDLE;
        default: bal_q <= cbv_pkg::BAL_IDLE;
      endcase
    end
  end

  // Samples captured once at cycle start
  always_ff @(posedge clk) begin
    if (reset) begin
      samples_q <= '0;
    end else if (cycle_start && bal_q == cbv_pkg::BAL_IDLE) begin
      for (int i = 0; i < cbv_pkg::CHANNELS; i++) begin
        if (active[i]) begin
          samples_q[i] <= channel_current[i];
        end else begin
          samples_q[i] <= 12'h000;
        end
      end
    end
  end

  // Cycle average current
  always_ff @(posedge clk) begin
    if (reset || !core_en_q) begin
      avg_q <= 12'h000;
    end else if (bal_q == cbv_pkg::BAL_AVG) begin
      avg_q <= avg_of(sum, chan_count_q);
    end
  end

  assign update = (bal_q == cbv_pkg::BAL_UPD);

  // One balance loop per channel
  generate
    for (genvar g = 0; g < cbv_pkg::CHANNELS; g++) begin : g_chan
      cbv_balance_chan u_chan (
        .clk(clk),
        .reset(reset),
        .active(active[g]),
        .update(update),
        .sample(samples_q[g]),
        .average(avg_q),
        .base_width(base_width_q),
        .result(channel_out[g])
      );
    end
  endgenerate

  // Outputs
  assign core_regulator_enable = core_en_q;
  assign secondary_regulator_enable = sec_en_q;
  assign parallel_code_mode = (mode_q == cbv_pkg::MODE_PARALLEL);
  assign serial_code_mode = (mode_q == cbv_pkg::MODE_SERIAL);
  assign reference_level = ref_q;
  assign cycle_average_current = {4'h0, avg_q};

endmodule // cbv_top

// file: verif/cbv_top_props.sv
// Checker for mode capture, regulator enables and code decode
`timescale 1ns/1ns
module cbv_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pins
  input wire logic enable_pin,
  input wire logic mode_select_code_bit1,
  input wire logic code_bit0,
  input wire logic code_bit2,
  input wire logic code_bit3,
  input wire logic code_bit4,
  input wire logic code_bit5,
  // Regulator control
  input wire logic core_regulator_enable,
  input wire logic secondary_regulator_enable,
  input wire logic parallel_code_mode,
  input wire logic serial_code_mode,
  input wire logic [13:0] reference_level
);
  logic [5:0] code;
  logic [5:0] code_q;
  logic [3:0] calm_q;
  logic [13:0] exp_ref;
  logic held;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Pin code and held mode
  assign code = {code_bit5, code_bit4, code_bit3, code_bit2,
    mode_select_code_bit1, code_bit0};
  assign held = parallel_code_mode || serial_code_mode;
  // Expected reference for the pin code
  always_comb begin
    if (code < 6'h20) begin
      exp_ref = 14'h3C8C - 14'h00FA * 14'(code);
    end else if (code <= 6'h3C) begin
      exp_ref = 14'h1DC9 - 14'h007D * 14'(code - 6'h20);
    end else begin
      exp_ref = 14'h101D;
    end
  end
  // Cycles since the code last moved, saturating
  always_ff @(posedge clk) begin
    code_q <= code;
    if (reset || code != code_q) begin
      calm_q <= 4'h0;
    end else if (calm_q != 4'hF) begin
      calm_q <= calm_q + 4'h1;
    end
  end
  property p_off_idle;
    !enable_pin [*6] |-> !core_regulator_enable
      && !secondary_regulator_enable;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("regulator on while enable low");
  property p_no_commit;
    !enable_pin [*6] |-> !held;
  endproperty
  a_no_commit: assert property (p_no_commit)
    else $error("mode held while enable low");
  property p_hold;
    enable_pin [*3] ##0 held |=>
      $stable({parallel_code_mode, serial_code_mode});
  endproperty
  a_hold: assert property (p_hold)
    else $error("mode moved while enabled");
  property p_par_cap;
    $rose(parallel_code_mode) |-> $past(mode_select_code_bit1, 4);
  endproperty
  a_par_cap: assert property (p_par_cap)
    else $error("parallel mode with select low");
  property p_ser_cap;
    $rose(serial_code_mode) |-> !$past(mode_select_code_bit1, 4);
  endproperty
  a_ser_cap: assert property (p_ser_cap)
    else $error("serial mode with select high");
  property p_par_sec;
    parallel_code_mode |-> !secondary_regulator_enable;
  endproperty
  a_par_sec: assert property (p_par_sec)
    else $error("secondary on in parallel mode");
  property p_core_run;
    held ##1 held |-> core_regulator_enable;
  endproperty
  a_core_run: assert property (p_core_run)
    else $error("core off while mode held");
  property p_ref;
    parallel_code_mode [*3] ##0 (calm_q > 4'h5 && code == code_q) |->
      reference_level == exp_ref;
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference does not match code");
  c_par: cover property ($rose(parallel_code_mode));
  c_ser: cover property ($rose(serial_code_mode));
  c_safe: cover property (parallel_code_mode && code == 6'h3F);
endmodule // cbv_checker

bind cbv_top cbv_checker u_chk (
  .clk(clk), .reset(reset), .enable_pin(enable_pin),
  .mode_select_code_bit1(mode_select_code_bit1),
  .code_bit0(code_bit0), .code_bit2(code_bit2), .code_bit3(code_bit3),
  .code_bit4(code_bit4), .code_bit5(code_bit5),
  .core_regulator_enable(core_regulator_enable),
  .secondary_regulator_enable(secondary_regulator_enable),
  .parallel_code_mode(parallel_code_mode),
  .serial_code_mode(serial_code_mode),
  .reference_level(reference_level)
);

// file: verif/cbv_proc_model.sv
// Processor side model driving the parallel code pins
`timescale 1ns/1ns
module cbv_proc_model (
  // Clock
  input wire logic clk,
  // Code pins
  output logic mode_select_code_bit1,
  output logic code_bit0,
  output logic code_bit2,
  output logic code_bit3,
  output logic code_bit4,
  output logic code_bit5
);
  // Pins start at code zero
  initial begin
    {code_bit5, code_bit4, code_bit3, code_bit2, mode_select_code_bit1,
      code_bit0} = 6'h00;
  end
  // All six pins change together at one edge, MSB on code_bit5
  task automatic put_code(input logic [5:0] c);
    @(posedge clk);
    {code_bit5, code_bit4, code_bit3, code_bit2, mode_select_code_bit1,
      code_bit0} <= c;
  endtask
endmodule // cbv_proc_model

// file: verif/tb_current_balance_vid_decode.sv
// Bench for mode capture, code decode, registers and current balance
`timescale 1ns/1ns
module tb_current_balance_vid_decode;
  logic clk;
  logic reset;
  logic enable_pin;
  logic sel, b0, b2, b3, b4, b5;
  logic [3:0][11:0] cur;
  logic [7:0] adr;
  logic rd_en;
  logic wr_en;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wait_req;
  logic core_en, sec_en, par_m, ser_m;
  logic [13:0] ref_lv;
  logic [15:0] avg;
  cbv_pkg::cbv_chan_out_type [3:0] chan;
  logic [31:0] rd;
  logic [7:0] ra [4] = '{8'h00, 8'h04, 8'h08, 8'h40};
  logic [31:0] re [4] = '{32'h4, 32'hFA, 32'h64, 32'h0};
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  cbv_proc_model u_proc (.clk(clk), .mode_select_code_bit1(sel),
    .code_bit0(b0), .code_bit2(b2), .code_bit3(b3), .code_bit4(b4),
    .code_bit5(b5));
  cbv_top DUT (.clk(clk), .reset(reset), .enable_pin(enable_pin),
    .mode_select_code_bit1(sel), .code_bit0(b0), .code_bit2(b2),
    .code_bit3(b3), .code_bit4(b4), .code_bit5(b5),
    .channel_current(cur), .avs_address(adr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .core_regulator_enable(core_en),
    .secondary_regulator_enable(sec_en), .parallel_code_mode(par_m),
    .serial_code_mode(ser_m), .reference_level(ref_lv),
    .cycle_average_current(avg), .channel_out(chan));
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Count and report one comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus write held until waitrequest is seen low
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  // Bus read, data taken at the edge waitrequest is low
  task automatic bus_read(input logic [7:0] a);
    adr <= a;
    rd_en <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    rd = rdata;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  // Select level set well ahead of the enable rise
  task automatic enable_with(input logic s);
    u_proc.put_code({4'h0, s, 1'b0});
    repeat (260) @(posedge clk);
    enable_pin <= 1'b1;
    repeat (10) @(posedge clk);
  endtask
  // Reference expected for a code
  function automatic logic [13:0] ref_of(input logic [5:0] c);
    if (c < 6'h20) return 14'h3C8C - 14'h00FA * 14'(c);
    if (c <= 6'h3C) return 14'h1DC9 - 14'h007D * 14'(c - 6'h20);
    return 14'h101D;
  endfunction
  // Counts and verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    enable_pin = 1'b0;
    cur = '0;
    adr = 8'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdata = 32'h0;
    reset = 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (ra[i]) begin
      bus_read(ra[i]);
      check(rd, re[i]);
    end
    bus_write(8'h00, 32'h7);
    bus_write(8'h04, 32'h1);
    bus_read(8'h00);
    check(rd, 32'h4);
    bus_read(8'h04);
    check(rd, 32'h4);
    $display("test registers done");
    enable_with(1'b0);
    check({28'h0, core_en, sec_en, par_m, ser_m}, 32'hD);
    bus_read(8'h10);
    check({27'h0, rd[4:0]}, 32'hB);
    bus_write(8'h0C, 32'h1234);
    repeat (2) @(posedge clk);
    check({18'h0, ref_lv}, 32'h1234);
    u_proc.put_code(6'h02);
    repeat (10) @(posedge clk);
    check({31'h0, ser_m}, 32'h1);
    enable_pin <= 1'b0;
    repeat (10) @(posedge clk);
    check({28'h0, core_en, sec_en, par_m, ser_m}, 32'h0);
    check({18'h0, ref_lv}, 32'h0);
    $display("test serial done");
    enable_with(1'b1);
    for (int c = 0; c < 64; c++) begin
      u_proc.put_code(6'(c));
      repeat (8) @(posedge clk);
      check({18'h0, ref_lv}, {18'h0, ref_of(6'(c))});
      check({29'h0, core_en, sec_en, par_m}, 32'h5);
    end
    $display("test parallel done");
    bus_write(8'h04, 32'h10);
    bus_write(8'h00, 32'h3);
    cur <= {12'hFFF, 12'h046, 12'h064, 12'h082};
    repeat (200) @(posedge clk);
    check({16'h0, avg}, 32'h64);
    check({31'h0, chan[0].balance_error > 16'sh0}, 32'h1);
    check({31'h0, chan[0].pulse_width < 16'h0064}, 32'h1);
    check({31'h0, chan[2].pulse_width > 16'h0064}, 32'h1);
    check(chan[3], 32'h0);
    bus_read(8'h18);
    check(rd, 32'h64);
    bus_write(8'h00, 32'h4);
    cur <= {12'h0A0, 12'h078, 12'h050, 12'h028};
    repeat (200) @(posedge clk);
    check({16'h0, avg}, 32'h64);
    check({31'h0, chan[3].pulse_width < 16'h0064}, 32'h1);
    check({31'h0, chan[0].pulse_width > 16'h0064}, 32'h1);
    $display("test balance done");
    enable_pin <= 1'b0;
    repeat (10) @(posedge clk);
    u_proc.put_code(6'h00);
    repeat (5) @(posedge clk);
    enable_pin <= 1'b1;
    repeat (10) @(posedge clk);
    bus_read(8'h10);
    check({27'h0, rd[4:0]}, 32'h1B);
    $display("test setup done");
    end_sim();
  end
endmodule // tb_current_balance_vid_decode
